/* File: include/pin_mux_consts.vh */
// Functional notes
// - Reset gives each pin to the port controller; nine functions optional.
// - A pin goes to its peripheral only while its route enable bit is one.
// - Functions A to I come from paired even/odd fields of one register.
// - Analog uses sit on function B; selecting B removes digital control.
// - A detected debugger switches the debug data pin to serial-wire data.
// - Only the debug clock goes through the ordinary mux, on pin 30.
// - Oscillator pins 14, 15, 0, 1 bypass the mux when claimed.
// - High-speed I2C is allowed only on pins 8, 9, 13, 16, 17, 22, 23.
// - An enabled analog peripheral conflicts with the pin's other functions.
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH
`define ADDR_ROUTE_EN      8'h00
`define ADDR_ANALOG_EN     8'h04
`define ADDR_OSC_CLAIM     8'h08
`define ADDR_STATUS        8'h0C
`define ADDR_CONFLICT      8'h10
`define ADDR_FUNC_BASE     8'h20
`define ADDR_FUNC_LAST     8'h2C
`define FUNC_FIELD_W       4
`define FUNC_A             4'h0
`define FUNC_B             4'h1
`define FUNC_G             4'h6
`define FUNC_I             4'h8
`define FUNC_RESET         4'h0
`define ROUTE_EN_RESET     32'h00000000
`define DEBUG_CLK_PIN      30
`define DEBUG_DATA_PIN     31
`define MAIN_OSC_PINS      32'h0000C000
`define SLOW_OSC_PINS      32'h00000003
`define HS_I2C_PINS        32'h00C32300
`define OSC_CLAIM_MAIN_BIT 0
`define OSC_CLAIM_SLOW_BIT 1
`endif

/* File: logic/pin_select.v */
`include "pin_mux_consts.vh"
module pin_select #(
  parameter NUM_FUNCS = 9
) (
  input  wire                 route_en_in,
  input  wire [3:0]           func_sel_in,
  input  wire                 osc_claim_in,
  input  wire                 dbg_data_in,
  input  wire [NUM_FUNCS-1:0] per_oe_in,
  input  wire [NUM_FUNCS-1:0] per_out_in,
  input  wire                 gpio_oe_in,
  input  wire                 gpio_out_in,
  input  wire                 dbg_oe_in,
  input  wire                 dbg_out_in,
  output reg                  pad_oe_out,
  output reg                  pad_out_out,
  output reg                  digital_off_out,
  output reg [NUM_FUNCS-1:0]  func_hit_out
);
  integer i;
  always @* begin
    pad_oe_out      = gpio_oe_in;
    pad_out_out     = gpio_out_in;
    digital_off_out = 1'b0;
    func_hit_out    = {NUM_FUNCS{1'b0}};
    if (osc_claim_in) begin
      pad_oe_out      = 1'b0;
      pad_out_out     = 1'b0;
      digital_off_out = 1'b1;
    end else if (dbg_data_in) begin
      pad_oe_out  = dbg_oe_in;
      pad_out_out = dbg_out_in;
    end else if (route_en_in) begin
      pad_oe_out  = 1'b0;
      pad_out_out = 1'b0;
      for (i = 0; i < NUM_FUNCS; i = i + 1) begin
        if (func_sel_in == i[3:0]) begin
          func_hit_out[i] = 1'b1;
          pad_oe_out      = per_oe_in[i];
          pad_out_out     = per_out_in[i];
        end
      end
      if (func_sel_in == `FUNC_B) begin
        pad_oe_out      = 1'b0;
        pad_out_out     = 1'b0;
        digital_off_out = 1'b1;
      end
    end
  end
endmodule

/* File: logic/pin_function_multiplexer.v */
`include "pin_mux_consts.vh"
module pin_function_multiplexer #(
  parameter NUM_PINS  = 32,
  parameter NUM_FUNCS = 9
) (
  input  wire                           mclk_in,
  input  wire                           rst_n_in,
  input  wire [7:0]                     addr_in,
  input  wire [31:0]                    wdata_in,
  input  wire                           wr_in,
  input  wire                           rd_in,
  output reg  [31:0]                    rdata_out,
  input  wire                           debugger_present_in,
  input  wire [NUM_PINS-1:0]            gpio_oe_in,
  input  wire [NUM_PINS-1:0]            gpio_out_in,
  input  wire [NUM_PINS*NUM_FUNCS-1:0]  per_oe_in,
  input  wire [NUM_PINS*NUM_FUNCS-1:0]  per_out_in,
  input  wire                           dbg_data_oe_in,
  input  wire                           dbg_data_out_in,
  input  wire [NUM_PINS-1:0]            i2c_hs_req_in,
  input  wire [NUM_PINS-1:0]            pad_in,
  output wire [NUM_PINS-1:0]            pad_oe_out,
  output wire [NUM_PINS-1:0]            pad_out_out,
  output wire [NUM_PINS-1:0]            pad_ie_out,
  output wire [NUM_PINS*NUM_FUNCS-1:0]  per_in_out,
  output wire [NUM_PINS-1:0]            gpio_in_out,
  output wire                           dbg_data_in_out,
  output wire                           dbg_clk_in_out,
  output wire [NUM_PINS-1:0]            i2c_hs_ok_out,
  output wire [NUM_PINS-1:0]            analog_conflict_out
);
  reg  [NUM_PINS-1:0]   route_en_ff;
  reg  [NUM_PINS-1:0]   analog_en_ff;
  reg  [1:0]            osc_claim_ff;
  reg  [NUM_PINS*4-1:0] func_ff;
  reg  [NUM_PINS-1:0]   i2c_err_ff;
  reg  [31:0]           nxt_rdata;
  wire [NUM_PINS-1:0]   osc_pins;
  wire [NUM_PINS-1:0]   dbg_data_pins;
  wire [NUM_PINS-1:0]   digital_off;
  wire [NUM_PINS-1:0]   hs_pins;
  wire [NUM_PINS*NUM_FUNCS-1:0] hits;
  wire [1:0]            func_word;

  // Four words of eight pins each cover all 32 pins
  assign func_word = addr_in[3:2];
  // Oscillator controllers take their pins ahead of everything else
  assign osc_pins =
    ({NUM_PINS{osc_claim_ff[`OSC_CLAIM_MAIN_BIT]}} &
     `MAIN_OSC_PINS) |
    ({NUM_PINS{osc_claim_ff[`OSC_CLAIM_SLOW_BIT]}} &
     `SLOW_OSC_PINS);
  assign dbg_data_pins = debugger_present_in ?
    ({{(NUM_PINS-1){1'b0}}, 1'b1} << `DEBUG_DATA_PIN) :
    {NUM_PINS{1'b0}};
  assign hs_pins = `HS_I2C_PINS;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_en_ff  <= `ROUTE_EN_RESET;
      analog_en_ff <= 32'h00000000;
      osc_claim_ff <= 2'h0;
      func_ff      <= {NUM_PINS{`FUNC_RESET}};
    end else if (wr_in) begin
      if (addr_in == `ADDR_ROUTE_EN) begin
        route_en_ff <= wdata_in[NUM_PINS-1:0];
      end else if (addr_in == `ADDR_ANALOG_EN) begin
        analog_en_ff <= wdata_in[NUM_PINS-1:0];
      end else if (addr_in == `ADDR_OSC_CLAIM) begin
        osc_claim_ff <= wdata_in[1:0];
      end else if (addr_in >= `ADDR_FUNC_BASE &&
                   addr_in <= `ADDR_FUNC_LAST) begin
        // One word holds four pin pairs: even field low, odd field high
        func_ff[func_word*32 +: 32] <= wdata_in;
      end
    end
  end

  // Sticky record of pins asked for HS I2C outside the allowed set
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      i2c_err_ff <= 32'h00000000;
    end else if (wr_in && addr_in == `ADDR_STATUS) begin
      i2c_err_ff <= (i2c_err_ff & ~wdata_in[NUM_PINS-1:0]) |
                    (i2c_hs_req_in & ~hs_pins);
    end else begin
      i2c_err_ff <= i2c_err_ff | (i2c_hs_req_in & ~hs_pins);
    end
  end

  assign i2c_hs_ok_out = i2c_hs_req_in & hs_pins;
  // Analog output fights any routed digital use of the pin
  assign analog_conflict_out = analog_en_ff &
    (route_en_ff | gpio_oe_in) & ~digital_off;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (addr_in == `ADDR_ROUTE_EN) begin
      nxt_rdata = route_en_ff;
    end else if (addr_in == `ADDR_ANALOG_EN) begin
      nxt_rdata = analog_en_ff;
    end else if (addr_in == `ADDR_OSC_CLAIM) begin
      nxt_rdata = {30'h00000000, osc_claim_ff};
    end else if (addr_in == `ADDR_STATUS) begin
      nxt_rdata = i2c_err_ff;
    end else if (addr_in == `ADDR_CONFLICT) begin
      nxt_rdata = analog_conflict_out;
    end else if (addr_in >= `ADDR_FUNC_BASE &&
                 addr_in <= `ADDR_FUNC_LAST) begin
      nxt_rdata = func_ff[func_word*32 +: 32];
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      rdata_out <= nxt_rdata;
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
      pin_select #(
        .NUM_FUNCS (NUM_FUNCS)
      ) u_sel (
        .route_en_in     (route_en_ff[p]),
        .func_sel_in     (func_ff[p*4 +: 4]),
        .osc_claim_in    (osc_pins[p]),
        .dbg_data_in     (dbg_data_pins[p]),
        .per_oe_in       (per_oe_in[p*NUM_FUNCS +: NUM_FUNCS]),
        .per_out_in      (per_out_in[p*NUM_FUNCS +: NUM_FUNCS]),
        .gpio_oe_in      (gpio_oe_in[p]),
        .gpio_out_in     (gpio_out_in[p]),
        .dbg_oe_in       (dbg_data_oe_in),
        .dbg_out_in      (dbg_data_out_in),
        .pad_oe_out      (pad_oe_out[p]),
        .pad_out_out     (pad_out_out[p]),
        .digital_off_out (digital_off[p]),
        .func_hit_out    (hits[p*NUM_FUNCS +: NUM_FUNCS])
      );
      // Input routing follows the same selection as the driver
      assign per_in_out[p*NUM_FUNCS +: NUM_FUNCS] =
        hits[p*NUM_FUNCS +: NUM_FUNCS] &
        {NUM_FUNCS{pad_in[p] & ~digital_off[p]}};
      assign pad_ie_out[p]  = ~digital_off[p];
      assign gpio_in_out[p] = pad_in[p] & ~digital_off[p];
    end
  endgenerate

  assign dbg_data_in_out = debugger_present_in &
                           pad_in[`DEBUG_DATA_PIN];
  // Debug clock only via the ordinary mux, function G on pin 30
  assign dbg_clk_in_out =
    per_in_out[`DEBUG_CLK_PIN*NUM_FUNCS + 6];
endmodule

/* File: verif/pad_far_end.sv */
module pad_far_end (
  input  wire logic        mclk_in,
  input  wire logic [31:0] pad_oe_in,
  input  wire logic [31:0] pad_out_in,
  output logic      [31:0] pad_lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] idle_ff = 32'h5A5AC3C3;
  // Undriven pads toggle each cycle so a stale level never passes
  always @(posedge mclk_in) idle_ff <= ~idle_ff;
  assign pad_lvl_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & idle_ff);
endmodule

/* File: verif/pin_mux_properties.sv */
`include "pin_mux_consts.vh"
module pin_mux_properties #(parameter NUM_PINS = 32) (
  input wire logic                mclk_in,
  input wire logic                rst_n_in,
  input wire logic [7:0]          addr_in,
  input wire logic [31:0]         wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [31:0]         rdata_out,
  input wire logic                debugger_present_in,
  input wire logic                dbg_data_oe_in,
  input wire logic                dbg_data_out_in,
  input wire logic                dbg_data_in_out,
  input wire logic [NUM_PINS-1:0] gpio_oe_in,
  input wire logic [NUM_PINS-1:0] i2c_hs_req_in,
  input wire logic [NUM_PINS-1:0] i2c_hs_ok_out,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_oe_out,
  input wire logic [NUM_PINS-1:0] pad_out_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] route_ff;
  // Shadow of the whole route enable word; the checks mask out oscillator and debug data pins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      route_ff <= 32'h0;
    else if (wr_in && addr_in == `ADDR_ROUTE_EN)
      route_ff <= wdata_in;
  end
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_hs_i2c_mask: assert property (
    i2c_hs_ok_out == (i2c_hs_req_in & `HS_I2C_PINS)) else $error("hs grant");
  a_dbg_data_oe: assert property (
    debugger_present_in |-> pad_oe_out[31] == dbg_data_oe_in)
    else $error("swd oe");
  a_dbg_data_out: assert property (
    debugger_present_in |-> pad_out_out[31] == dbg_data_out_in)
    else $error("swd");
  a_dbg_data_in: assert property (
    debugger_present_in |-> dbg_data_in_out == pad_in[31])
    else $error("swd in");
  a_rdata_idle: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0) else $error("rdata not idle");
  a_route_readback: assert property (
    $past(rd_in) && $past(addr_in) == 8'h00 |-> rdata_out == route_ff)
    else $error("route readback");
  a_gpio_owns_pin: assert property (
    ((pad_oe_out ^ gpio_oe_in) & ~route_ff & 32'h7FFF3FFC) == 32'h0)
    else $error("port controller lost pin");
  a_write_next_cycle: assert property (
    $past(wr_in) && $past(addr_in) == 8'h00 |-> ((pad_oe_out ^ gpio_oe_in)
    & ~$past(wdata_in) & 32'h7FFF3FFC) == 32'h0) else $error("late update");
  c_debugger: cover property (debugger_present_in && dbg_data_oe_in);
  c_readback: cover property ($past(rd_in) && rdata_out != 32'h0);
  c_hs_grant: cover property (i2c_hs_ok_out != 32'h0);
endmodule
bind pin_function_multiplexer pin_mux_properties #(.NUM_PINS(NUM_PINS))
  u_props (.*);

/* File: verif/pin_function_multiplexer_tb.sv */
`include "pin_mux_consts.vh"
module pin_function_multiplexer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk_in, rst_n_in, wr_in, rd_in, debugger_present_in;
  logic         dbg_data_oe_in, dbg_data_out_in, dbg_data_in_out;
  logic         dbg_clk_in_out;
  logic [7:0]   addr_in;
  logic [31:0]  wdata_in, rdata_out, gpio_oe_in, gpio_out_in, pad_in;
  logic [31:0]  pad_oe_out, pad_out_out, pad_ie_out, gpio_in_out, rv;
  logic [31:0]  i2c_hs_req_in, i2c_hs_ok_out, analog_conflict_out;
  logic [287:0] per_oe_in, per_out_in, per_in_out;
  int           miscompares = 0, total_checks = 0, seed = 32'hFE63, c;
  pin_function_multiplexer dut (.*);
  pad_far_end far (.mclk_in(mclk_in), .pad_oe_in(pad_oe_out),
                   .pad_out_in(pad_out_out), .pad_lvl_out(pad_in));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic shuffle;
    gpio_oe_in <= $random(seed);
    gpio_out_in <= $random(seed);
    i2c_hs_req_in <= $random(seed);
    per_oe_in <= {9{$random(seed)}};
    per_out_in <= {9{$random(seed)}};
    {dbg_data_oe_in, dbg_data_out_in} <= 2'($random(seed));
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #4 rv = rdata_out;
  endtask
  function automatic logic [31:0] fword(int f);
    return (f << 8) | (((f + 1) % 10) << 12);
  endfunction
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (2000) @(posedge mclk_in);
    miscompares++;
    complete_run;
  end
  initial begin
    {rst_n_in, wr_in, rd_in, debugger_present_in} = 4'h0;
    {addr_in, wdata_in} = 40'h0;
    shuffle;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #4 chk("pad oe", pad_oe_out, gpio_oe_in);
    chk("port in", gpio_in_out, pad_in);
    wr(`ADDR_ROUTE_EN, 32'h0000000C);
    for (int f = 0; f < 10; f++) begin
      @(posedge mclk_in);
      shuffle;
      wr(`ADDR_FUNC_BASE, fword(f));
      #4;
      for (int p = 2; p < 4; p++) begin
        c = (p == 2) ? f : (f + 1) % 10;
        chk("oe", pad_oe_out[p], c < 9 && c != 1 && per_oe_in[p*9+c]);
        if (c == 1) chk("ie", pad_ie_out[p], 1'b0);
        else if (c < 9) chk("out", pad_out_out[p], per_out_in[p*9+c]);
        rv = (c < 9 && c != 1) ? 32'(pad_in[p]) << c : 32'h0;
        chk("in", per_in_out[p*9 +: 9], rv);
      end
    end
    rd(`ADDR_ROUTE_EN);
    chk("route en", rv, 32'h0000000C);
    rd(`ADDR_FUNC_BASE);
    chk("func word", rv, fword(9));
    rd(8'hF0);
    chk("unmapped", rv, 32'h0);
    wr(`ADDR_OSC_CLAIM, 32'h3);
    #4 chk("osc ie", pad_ie_out & 32'h0000C003, 32'h0);
    chk("osc oe", pad_oe_out & 32'h0000C003, 32'h0);
    wr(`ADDR_OSC_CLAIM, 32'h0);
    wr(`ADDR_ROUTE_EN, 32'hC0000000);
    wr(`ADDR_FUNC_LAST, 32'h06000000);
    debugger_present_in <= 1'b1;
    #4 chk("swd oe", pad_oe_out[31], dbg_data_oe_in);
    chk("swd in", dbg_data_in_out, pad_in[31]);
    chk("swclk", dbg_clk_in_out, pad_in[30]);
    @(posedge mclk_in);
    debugger_present_in <= 1'b0;
    #4 chk("pin31 oe", pad_oe_out[31], per_oe_in[279]);
    chk("swd idle", dbg_data_in_out, 1'b0);
    chk("hs ok", i2c_hs_ok_out, i2c_hs_req_in & `HS_I2C_PINS);
    // Mid-run reset must hand every pin back to the port controller
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #4 chk("reset oe", pad_oe_out, gpio_oe_in);
    rd(`ADDR_FUNC_LAST);
    chk("reset func", rv, 32'h0);
    wr(`ADDR_ROUTE_EN, 32'h0);
    wr(`ADDR_ANALOG_EN, 32'h20);
    gpio_oe_in[5] <= 1'b1;
    #4 chk("conflict", analog_conflict_out[5], 1'b1);
    chk("released", pad_oe_out, gpio_oe_in);
    rd(`ADDR_CONFLICT);
    chk("conflict reg", rv, 32'h00000020);
    @(posedge mclk_in);
    i2c_hs_req_in <= 32'h0;
    wr(`ADDR_STATUS, 32'hFFFFFFFF);
    rd(`ADDR_STATUS);
    chk("hs clear", rv, 32'h0);
    @(posedge mclk_in);
    i2c_hs_req_in <= 32'h00000030;
    @(posedge mclk_in);
    i2c_hs_req_in <= 32'h00000010;
    // Clear of pins 4 and 5 meets a new event on pin 4: the event wins
    wr(`ADDR_STATUS, 32'h00000030);
    i2c_hs_req_in <= 32'h0;
    rd(`ADDR_STATUS);
    chk("hs sticky", rv, 32'h00000010);
    complete_run;
  end
endmodule
